//--- logic/imu_timing_defines.svh
/*
  Register offsets, field positions, reset values and timing figures of the
  sample timing and decimation control block.
  Assumes a 16-bit register map reached one byte per serial write frame.
*/
`ifndef IMU_TIMING_DEFINES_SVH
`define IMU_TIMING_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets (low byte at the even address)
// ----------------------------------------------------------------
`define MISC_CONTROL_ADDR 7'h60
`define SCALE_FACTOR_ADDR 7'h62
`define DECIMATION_ADDR 7'h64
`define BIAS_CONFIG_ADDR 7'h66
`define GLOBAL_COMMAND_ADDR 7'h68

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define MISC_CONTROL_RESET 16'h00C1
`define MISC_CONTROL_MASK 16'h1FCF
`define SCALE_FACTOR_RESET 16'h07D0
`define DECIMATION_RESET 16'h0000
`define DECIMATION_MASK 16'h07FF
`define BIAS_CONFIG_RESET 16'h070A
`define BIAS_CONFIG_MASK 16'h3F0F

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MSC_BW_BIT 12
`define MSC_FAST_BIT 11
`define MSC_TS32_BIT 10
`define MSC_BURST32_BIT 9
`define MSC_OUTSEL_BIT 8
`define MSC_GSENS_BIT 7
`define MSC_POP_BIT 6
`define MSC_MODE_HI 3
`define MSC_MODE_LO 2
`define MSC_SYNCPOL_BIT 1
`define MSC_DRPOL_BIT 0
`define BIAS_EN_HI 13
`define BIAS_EN_LO 8
`define BIAS_TBC_HI 3
`define BIAS_TBC_LO 0
`define CMD_BIAS_UPDATE_BIT 0

// ----------------------------------------------------------------
// Limits and timing
// ----------------------------------------------------------------
`define DECIMATION_MAX 11'h07CF
`define TBC_MAX 4'hC
`define BIAS_WINDOW_BASES 64
`define SYS_CLK_HZ 10000000
`define RATE_SLOW_HZ 2000
`define RATE_FAST_HZ 4000
`define SYNC_MIN_MHZ 800
`define SYNC_MAX_HZ 400
`define GYRO_DELAY_US 170
`define ACCEL_DELAY_US 630
`define TS16_LSB_PS 49020000
`define TS32_LSB_PS 19230
`define SYNC_PULSE_US 10
`define DR_UPDATE_US 20

`endif

//--- logic/imu_timing_pkg.sv
/*
  Types shared by the sample timing and decimation control block.
  Assumes the numeric constants live in imu_timing_defines.svh.
*/
package imu_timing_pkg;

  typedef enum logic [1:0] {
    MODE_INTERNAL = 2'b00,
    MODE_DIRECT = 2'b01,
    MODE_SCALED = 2'b10,
    MODE_OUTPUT = 2'b11
  } timing_mode_t;

  typedef enum logic [1:0] {
    DR_STABLE = 2'b01,
    DR_UPDATE = 2'b10
  } dr_state_t;

endpackage

//--- logic/imu_sample_timing.sv
/*
  Sample clock, external sync, decimation, data-ready and bias estimator
  timing control of an inertial module, with its serial register port.
  Assumes a host on a mode-3 serial port (sclk idles high, cs_n low per
  16-bit frame, bit 15 first) and leaves at least three clk_sys periods plus
  four sclk periods between frames.
*/
`timescale 1ns/1ps
`include "imu_timing_defines.svh"

module imu_sample_timing #(
  parameter int SLOW_PERIOD = `SYS_CLK_HZ / `RATE_SLOW_HZ,
  parameter int FAST_PERIOD = `SYS_CLK_HZ / `RATE_FAST_HZ,
  parameter int SYNC_PERIOD_MAX = (`SYS_CLK_HZ / `SYNC_MIN_MHZ) * 1000,
  parameter int SYNC_PERIOD_MIN = `SYS_CLK_HZ / `SYNC_MAX_HZ
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic serial_clk,
  input wire logic serial_cs_n,
  input wire logic serial_din,
  output logic serial_dout,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  output logic data_ready_pin,
  output logic sample_tick,
  output logic output_tick,
  output logic sensor_bandwidth_select,
  output logic wide_timestamp_select,
  output logic burst_wide_active,
  output logic delta_output_select,
  output logic accel_sensitivity_comp_enable,
  output logic point_of_percussion_enable,
  output logic [5:0] bias_axis_enable,
  output logic bias_window_done,
  output logic bias_apply_command
);

  // Group delays of the medium bandwidth and pin pulse widths, in cycles; the delays only feed the parameter check
  localparam int GYRO_DELAY_CYC = `GYRO_DELAY_US * (`SYS_CLK_HZ / 1000000);
  localparam int ACCEL_DELAY_CYC = `ACCEL_DELAY_US * (`SYS_CLK_HZ / 1000000);
  localparam int SYNC_PULSE_CYC = `SYNC_PULSE_US * (`SYS_CLK_HZ / 1000000);
  localparam int DR_UPDATE_CYC = `DR_UPDATE_US * (`SYS_CLK_HZ / 1000000);

  generate
    if (SLOW_PERIOD < 4 || FAST_PERIOD < 4 || SLOW_PERIOD >= 65536 ||
        FAST_PERIOD > SLOW_PERIOD || SYNC_PERIOD_MIN < 2 ||
        SYNC_PERIOD_MAX <= SYNC_PERIOD_MIN || GYRO_DELAY_CYC < 1 ||
        ACCEL_DELAY_CYC < 1 || DR_UPDATE_CYC >= FAST_PERIOD) begin : g_bad
      $error("imu_sample_timing: unsupported timing parameters");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Serial clock domain: frame shift and hand-off
  // ----------------------------------------------------------------
  // The frame logic is reset by cs_n, so nothing relies on sclk edges
  // outside a frame.
  wire frame_rst_n = rst_n & ~serial_cs_n;
  logic [3:0] bit_cnt_reg;
  logic [14:0] shift_in_reg;
  logic [15:0] word_reg;
  logic word_tgl_reg;
  logic [15:0] read_snap_reg;
  logic dout_reg;
  logic [15:0] read_data_reg;

  always_ff @(posedge serial_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_reg <= 4'h0;
      shift_in_reg <= 15'h0000;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      shift_in_reg <= {shift_in_reg[13:0], serial_din};
    end
  end

  wire frame_last_bit = (bit_cnt_reg == 4'hF) & ~serial_cs_n;

  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_reg <= 16'h0000;
      word_tgl_reg <= 1'b0;
    end else if (frame_last_bit) begin
      word_reg <= {shift_in_reg, serial_din};
      word_tgl_reg <= ~word_tgl_reg;
    end
  end

  // Read data is snapped at the first falling edge; it was settled in the
  // system domain after the previous frame, which the frame gap guarantees.
  always_ff @(negedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      read_snap_reg <= 16'h0000;
      dout_reg <= 1'b0;
    end else if (!serial_cs_n) begin
      if (bit_cnt_reg == 4'h0) begin
        read_snap_reg <= read_data_reg;
        dout_reg <= read_data_reg[15];
      end else begin
        dout_reg <= read_snap_reg[~bit_cnt_reg];
      end
    end
  end
  assign serial_dout = dout_reg;

  // ----------------------------------------------------------------
  // Crossing into the system domain
  // ----------------------------------------------------------------
  logic tgl_meta_reg;
  logic tgl_sync_reg;
  logic tgl_seen_reg;
  logic sync_meta_reg;
  logic sync_sync_reg;
  logic sync_prev_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tgl_meta_reg <= 1'b0;
      tgl_sync_reg <= 1'b0;
      tgl_seen_reg <= 1'b0;
      sync_meta_reg <= 1'b0;
      sync_sync_reg <= 1'b0;
      sync_prev_reg <= 1'b0;
    end else if (clk_en) begin
      tgl_meta_reg <= word_tgl_reg;
      tgl_sync_reg <= tgl_meta_reg;
      tgl_seen_reg <= tgl_sync_reg;
      sync_meta_reg <= sync_in;
      sync_sync_reg <= sync_meta_reg;
      sync_prev_reg <= sync_sync_reg;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  wire frame_valid = clk_en & (tgl_sync_reg != tgl_seen_reg);
  wire frame_write = frame_valid & word_reg[15];
  wire [6:0] frame_addr = word_reg[14:8];
  wire [7:0] frame_byte = word_reg[7:0];
  wire [6:0] word_addr = {frame_addr[6:1], 1'b0};
  wire frame_high = frame_addr[0];
  wire [15:0] byte_merge_mask = frame_high ? 16'hFF00 : 16'h00FF;
  wire [15:0] byte_merge_data = {frame_byte, frame_byte};

  logic [15:0] misc_control_reg;
  logic [15:0] scale_factor_reg;
  logic [15:0] decimation_reg;
  logic [15:0] bias_config_reg;
  logic bias_cmd_reg;

  // Each byte lands as it arrives: a half-written word is live until its
  // second frame, which is why the host pairs low then high.
  wire wr_misc = frame_write & (word_addr == `MISC_CONTROL_ADDR);
  wire wr_scale = frame_write & (word_addr == `SCALE_FACTOR_ADDR);
  wire wr_dec = frame_write & (word_addr == `DECIMATION_ADDR);
  wire wr_bias = frame_write & (word_addr == `BIAS_CONFIG_ADDR);
  wire wr_cmd_low = frame_write & (frame_addr == `GLOBAL_COMMAND_ADDR);

  wire [15:0] misc_control_next = ((misc_control_reg & ~byte_merge_mask) |
    (byte_merge_data & byte_merge_mask)) & `MISC_CONTROL_MASK;
  wire [15:0] scale_factor_next = (scale_factor_reg & ~byte_merge_mask) |
    (byte_merge_data & byte_merge_mask);
  wire [15:0] decimation_next = ((decimation_reg & ~byte_merge_mask) |
    (byte_merge_data & byte_merge_mask)) & `DECIMATION_MASK;
  wire [15:0] bias_config_next = ((bias_config_reg & ~byte_merge_mask) |
    (byte_merge_data & byte_merge_mask)) & `BIAS_CONFIG_MASK;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      misc_control_reg <= `MISC_CONTROL_RESET;
      scale_factor_reg <= `SCALE_FACTOR_RESET;
      decimation_reg <= `DECIMATION_RESET;
      bias_config_reg <= `BIAS_CONFIG_RESET;
      bias_cmd_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_misc) misc_control_reg <= misc_control_next;
      if (wr_scale) scale_factor_reg <= scale_factor_next;
      if (wr_dec) decimation_reg <= decimation_next;
      if (wr_bias) bias_config_reg <= bias_config_next;
      bias_cmd_reg <= wr_cmd_low & frame_byte[`CMD_BIAS_UPDATE_BIT];
    end
  end

  // Reads return the full word; the command word and unmapped addresses
  // read as zero.
  wire [15:0] read_mux =
    (word_addr == `MISC_CONTROL_ADDR) ? misc_control_reg :
    (word_addr == `SCALE_FACTOR_ADDR) ? scale_factor_reg :
    (word_addr == `DECIMATION_ADDR) ? decimation_reg :
    (word_addr == `BIAS_CONFIG_ADDR) ? bias_config_reg :
    16'h0000;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      read_data_reg <= 16'h0000;
    end else if (frame_valid && !word_reg[15]) begin
      read_data_reg <= read_mux;
    end
  end

  // ----------------------------------------------------------------
  // Control field decode
  // ----------------------------------------------------------------
  wire [1:0] mode_bits = misc_control_reg[`MSC_MODE_HI:`MSC_MODE_LO];
  wire mode_internal = (mode_bits == imu_timing_pkg::MODE_INTERNAL);
  wire mode_direct = (mode_bits == imu_timing_pkg::MODE_DIRECT);
  wire mode_scaled = (mode_bits == imu_timing_pkg::MODE_SCALED);
  wire mode_output = (mode_bits == imu_timing_pkg::MODE_OUTPUT);
  wire timing_pin_polarity = misc_control_reg[`MSC_SYNCPOL_BIT];
  wire data_ready_polarity = misc_control_reg[`MSC_DRPOL_BIT];
  wire fast_rate = misc_control_reg[`MSC_FAST_BIT];
  wire [10:0] dec_field = decimation_reg[10:0];
  wire [10:0] dec_limit = (dec_field > `DECIMATION_MAX) ? `DECIMATION_MAX : dec_field;
  wire [3:0] tbc_field = bias_config_reg[`BIAS_TBC_HI:`BIAS_TBC_LO];
  wire [3:0] tbc_limit = (tbc_field > `TBC_MAX) ? `TBC_MAX : tbc_field;

  // Only the selected edge counts, so the sync duty cycle is free.
  wire sync_edge = timing_pin_polarity ? (sync_sync_reg & ~sync_prev_reg) :
    (~sync_sync_reg & sync_prev_reg);

  // ----------------------------------------------------------------
  // Internal sample clock
  // ----------------------------------------------------------------
  logic [15:0] int_cnt_reg;
  wire [15:0] int_period = fast_rate ? FAST_PERIOD[15:0] : SLOW_PERIOD[15:0];
  wire int_wrap = (int_cnt_reg >= int_period - 16'h0001);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      int_cnt_reg <= 16'h0000;
    end else if (clk_en) begin
      int_cnt_reg <= int_wrap ? 16'h0000 : int_cnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Scaled sync: period measurement and rate multiplier
  // ----------------------------------------------------------------
  // The accumulator adds the scale factor every cycle and emits one sample
  // per sync period's worth, giving scale factor samples per sync period
  // without a divider. Periods outside the allowed sync band stop it.
  logic [31:0] period_cnt_reg;
  logic [31:0] period_reg;
  logic period_ok_reg;
  logic [32:0] phase_acc_reg;
  wire [32:0] phase_sum = phase_acc_reg + {17'h0_0000, scale_factor_reg};
  wire phase_hit = period_ok_reg & (phase_sum >= {1'b0, period_reg});
  wire period_in_band = (period_cnt_reg >= SYNC_PERIOD_MIN[31:0]) &
    (period_cnt_reg <= SYNC_PERIOD_MAX[31:0]);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt_reg <= 32'h0000_0000;
      period_reg <= 32'h0000_0000;
      period_ok_reg <= 1'b0;
      phase_acc_reg <= 33'h0_0000_0000;
    end else if (clk_en) begin
      if (sync_edge) begin
        period_cnt_reg <= 32'h0000_0001;
        period_reg <= period_cnt_reg;
        period_ok_reg <= period_in_band;
      end else if (period_cnt_reg > SYNC_PERIOD_MAX[31:0]) begin
        period_ok_reg <= 1'b0;
      end else begin
        period_cnt_reg <= period_cnt_reg + 32'h0000_0001;
      end
      if (!mode_scaled || !period_ok_reg) begin
        phase_acc_reg <= 33'h0_0000_0000;
      end else if (phase_hit) begin
        phase_acc_reg <= phase_sum - {1'b0, period_reg};
      end else begin
        phase_acc_reg <= phase_sum;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sample tick selection and decimation
  // ----------------------------------------------------------------
  // Direct mode takes the sync edge as is; the scale factor is unused there.
  wire sample_now = ((mode_internal | mode_output) & int_wrap) |
    (mode_direct & sync_edge) |
    (mode_scaled & phase_hit);

  logic [10:0] dec_cnt_reg;
  wire dec_done = (dec_cnt_reg >= dec_limit);
  wire output_now = sample_now & dec_done;
  logic sample_reg;
  logic output_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dec_cnt_reg <= 11'h000;
      sample_reg <= 1'b0;
      output_reg <= 1'b0;
    end else if (clk_en) begin
      sample_reg <= sample_now;
      output_reg <= output_now;
      if (sample_now) begin
        dec_cnt_reg <= dec_done ? 11'h000 : dec_cnt_reg + 11'h001;
      end
    end
  end
  assign sample_tick = sample_reg;
  assign output_tick = output_reg;

  // ----------------------------------------------------------------
  // Data-ready and sync output pins
  // ----------------------------------------------------------------
  imu_timing_pkg::dr_state_t dr_state_reg;
  imu_timing_pkg::dr_state_t dr_state_next;
  logic [15:0] dr_cnt_reg;
  logic dr_pin_reg;
  logic [15:0] sync_cnt_reg;
  logic sync_out_reg;
  logic sync_oe_reg;
  wire dr_done = (dr_cnt_reg >= DR_UPDATE_CYC[15:0] - 16'h0001);

  always_comb begin
    dr_state_next = dr_state_reg;
    unique case (dr_state_reg)
      imu_timing_pkg::DR_STABLE: begin
        if (output_now) dr_state_next = imu_timing_pkg::DR_UPDATE;
      end
      imu_timing_pkg::DR_UPDATE: begin
        if (dr_done) dr_state_next = imu_timing_pkg::DR_STABLE;
      end
      default: dr_state_next = imu_timing_pkg::DR_STABLE;
    endcase
  end

  wire dr_stable_next = (dr_state_next == imu_timing_pkg::DR_STABLE);
  wire sync_active = (sync_cnt_reg != 16'h0000);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dr_state_reg <= imu_timing_pkg::DR_STABLE;
      dr_cnt_reg <= 16'h0000;
      dr_pin_reg <= 1'b0;
      sync_cnt_reg <= 16'h0000;
      sync_out_reg <= 1'b0;
      sync_oe_reg <= 1'b0;
    end else if (clk_en) begin
      dr_state_reg <= dr_state_next;
      dr_cnt_reg <= (dr_state_reg == imu_timing_pkg::DR_UPDATE) ?
        dr_cnt_reg + 16'h0001 : 16'h0000;
      dr_pin_reg <= dr_stable_next ? data_ready_polarity : ~data_ready_polarity;
      if (mode_output && sample_now) begin
        sync_cnt_reg <= SYNC_PULSE_CYC[15:0];
      end else if (sync_active) begin
        sync_cnt_reg <= sync_cnt_reg - 16'h0001;
      end
      sync_oe_reg <= mode_output;
      sync_out_reg <= (mode_output & sync_active) ? timing_pin_polarity : ~timing_pin_polarity;
    end
  end
  assign data_ready_pin = dr_pin_reg;
  assign sync_out = sync_out_reg;
  assign sync_oe = sync_oe_reg;

  // ----------------------------------------------------------------
  // Output format controls
  // ----------------------------------------------------------------
  // The wide burst format only switches on a data-ready boundary, so a
  // burst never mixes formats within one sample set.
  logic burst_wide_reg;
  logic [5:0] fmt_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      burst_wide_reg <= 1'b0;
      fmt_reg <= 6'h00;
    end else if (clk_en) begin
      if (output_now) burst_wide_reg <= misc_control_reg[`MSC_BURST32_BIT];
      fmt_reg <= {misc_control_reg[`MSC_BW_BIT],
        misc_control_reg[`MSC_TS32_BIT],
        misc_control_reg[`MSC_OUTSEL_BIT],
        misc_control_reg[`MSC_GSENS_BIT],
        misc_control_reg[`MSC_POP_BIT],
        1'b0};
    end
  end
  assign burst_wide_active = burst_wide_reg;
  assign sensor_bandwidth_select = fmt_reg[5];
  assign wide_timestamp_select = fmt_reg[4];
  assign delta_output_select = fmt_reg[3];
  assign accel_sensitivity_comp_enable = fmt_reg[2];
  assign point_of_percussion_enable = fmt_reg[1];

  // ----------------------------------------------------------------
  // Continuous bias estimator timing
  // ----------------------------------------------------------------
  // One base time is 2^exponent samples; a window is 64 base times. An
  // exponent change mid-way is not tracked and does not restart the window,
  // so the first window after a change may be short.
  logic [12:0] base_cnt_reg;
  logic [5:0] window_cnt_reg;
  logic window_done_reg;
  logic [5:0] bias_en_reg;
  logic bias_cmd_out_reg;
  wire [12:0] base_last = 13'((14'h0001 << tbc_limit) - 14'h0001);
  wire base_hit = sample_now & (base_cnt_reg >= base_last);
  wire window_hit = base_hit & (window_cnt_reg == 6'(`BIAS_WINDOW_BASES - 1));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      base_cnt_reg <= 13'h0000;
      window_cnt_reg <= 6'h00;
      window_done_reg <= 1'b0;
      bias_en_reg <= 6'h00;
      bias_cmd_out_reg <= 1'b0;
    end else if (clk_en) begin
      if (sample_now) begin
        base_cnt_reg <= base_hit ? 13'h0000 : base_cnt_reg + 13'h0001;
      end
      if (base_hit) window_cnt_reg <= window_cnt_reg + 6'h01;
      window_done_reg <= window_hit;
      bias_en_reg <= bias_config_reg[`BIAS_EN_HI:`BIAS_EN_LO];
      bias_cmd_out_reg <= bias_cmd_reg;
    end
  end
  assign bias_window_done = window_done_reg;
  assign bias_axis_enable = bias_en_reg;
  assign bias_apply_command = bias_cmd_out_reg;

endmodule

//--- tb/imu_timing_chk.sv
/*
  Port checker for the sample timing block.
  Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ps
module imu_timing_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sample_tick,
  input wire logic output_tick,
  input wire logic data_ready_pin,
  input wire logic sync_out,
  input wire logic sync_oe,
  input wire logic burst_wide_active,
  input wire logic bias_window_done,
  input wire logic bias_apply_command
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  tick_pair_a: assert property (output_tick |-> sample_tick)
    else $error("output tick without sample tick");
  dr_stands_a: assert property (output_tick |=> $stable(data_ready_pin)[*8])
    else $error("data ready not held");
  dr_restore_a: assert property (output_tick |-> ##[190:210] $changed(data_ready_pin))
    else $error("data ready not restored");
  sample_gap_a: assert property (sample_tick |=> !sample_tick[*8])
    else $error("samples too close");
  apply_pulse_a: assert property (bias_apply_command |=> !bias_apply_command[*8])
    else $error("command strobe too long");
  window_pulse_a: assert property (bias_window_done |=> !bias_window_done[*8])
    else $error("window pulse too long");
  burst_switch_a: assert property ($changed(burst_wide_active) |-> output_tick || $past(output_tick))
    else $error("burst width changed off data ready");
  sync_stands_a: assert property (sync_oe && $past(sync_oe) && $changed(sync_out) |=> $stable(sync_out)[*8])
    else $error("sync pulse too short");
  oe_hold_a: assert property ($rose(sync_oe) |=> sync_oe[*8])
    else $error("sync drive dropped");
  cover property (output_tick);
  cover property (bias_apply_command);
  cover property (sync_oe && sample_tick);
endmodule

//--- tb/host_model.sv
/*
  Host serial master and sync source.
  Assumes 16-bit frames, link clock idling high and running only in frames.
*/
`timescale 1ns/1ps
module host_model (
  output logic serial_clk,
  output logic serial_cs_n,
  output logic serial_din,
  input wire logic serial_dout,
  output logic sync_in
);
  initial begin
    serial_clk = 1'b1;
    serial_cs_n = 1'b1;
    serial_din = 1'b0;
    sync_in = 1'b0;
  end
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    serial_cs_n = 1'b0;
    #3.3;
    for (int i = 15; i >= 0; i--) begin
      serial_clk = 1'b0;
      serial_din = w[i];
      #7.5;
      serial_clk = 1'b1;
      r[i] = serial_dout;
      #7.5;
    end
    serial_cs_n = 1'b1;
    // Released line shows no stale bit
    serial_din = ~serial_din;
    #700;
  endtask
  task automatic sync_pulses(input int n, input int half_ns);
    repeat (n) begin
      sync_in = 1'b0;
      #(half_ns);
      sync_in = 1'b1;
      #(half_ns);
    end
  endtask
endmodule

//--- tb/tb.sv
/*
  Self-checking bench of the sample timing block.
  Assumes host_model as serial master and sync source.
*/
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic sclk, cs_n, din, dout, hsync, sout, soe, drdy, st, ot, bw, ts, bst, dl, gs, pop, bac;
  logic bwd;
  logic [5:0] bae;
  logic [15:0] r;
  int err_count = 0;
  int tests_run = 0;
  int ns, no, na, nw;
  logic [6:0] ad [5] = '{7'h60, 7'h62, 7'h64, 7'h66, 7'h68};
  logic [15:0] rv [5] = '{16'h00c1, 16'h07d0, 16'h0000, 16'h070a, 16'h0000};
  // The sync pin is shared: the device wins while it drives
  wire sync_pin = soe ? sout : hsync;
  host_model host (.serial_clk(sclk), .serial_cs_n(cs_n), .serial_din(din),
    .serial_dout(dout), .sync_in(hsync));
  imu_sample_timing #(.SLOW_PERIOD(400), .FAST_PERIOD(300), .SYNC_PERIOD_MAX(1000),
    .SYNC_PERIOD_MIN(10)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1), .serial_clk(sclk),
    .serial_cs_n(cs_n), .serial_din(din), .serial_dout(dout), .sync_in(sync_pin),
    .sync_out(sout), .sync_oe(soe), .data_ready_pin(drdy), .sample_tick(st),
    .output_tick(ot), .sensor_bandwidth_select(bw), .wide_timestamp_select(ts),
    .burst_wide_active(bst), .delta_output_select(dl), .accel_sensitivity_comp_enable(gs),
    .point_of_percussion_enable(pop), .bias_axis_enable(bae), .bias_window_done(bwd),
    .bias_apply_command(bac));
  initial forever #50 clk_sys = ~clk_sys;
  task automatic complete_run;
    if (err_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] x;
    host.xfer({1'b1, a, d}, x);
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] x);
    host.xfer({1'b0, a, 8'h00}, x);
    host.xfer(16'h0000, x);
  endtask
  task automatic cnt(input int n);
    ns = 0;
    no = 0;
    na = 0;
    nw = 0;
    repeat (n) begin
      @(negedge clk_sys);
      ns += st;
      no += ot;
      na += bac;
      nw += bwd;
    end
  endtask
  initial begin
    // Allows for the whole sequence with ample margin
    #5000000;
    err_count++;
    complete_run();
  end
  initial begin
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    for (int i = 0; i < 5; i++) begin
      rd(ad[i], r);
      chk(r, rv[i]);
    end
    chk({11'h000, bw, ts, dl, gs, pop}, 16'h0003);
    chk({15'h0000, drdy}, 16'h0001);
    cnt(2000);
    chk(16'(ns >= 4 && ns <= 6), 16'h0001);
    chk(16'(no), 16'(ns));
    wr(7'h60, 8'h31);
    wr(7'h61, 8'hf5);
    rd(7'h60, r);
    chk(r, 16'h1501);
    chk({11'h000, bw, ts, dl, gs, pop}, 16'h001c);
    wr(7'h64, 8'h01);
    wr(7'h61, 8'h0a);
    cnt(3000);
    chk(16'(ns >= 9 && ns <= 11), 16'h0001);
    chk(16'(no * 2 >= ns - 1 && no * 2 <= ns + 1), 16'h0001);
    chk({15'h0000, bst}, 16'h0001);
    wr(7'h60, 8'h07);
    fork
      host.sync_pulses(5, 20000);
      cnt(2000);
    join
    chk(16'(ns), 16'h0005);
    wr(7'h60, 8'h0d);
    cnt(700);
    chk({15'h0000, soe}, 16'h0001);
    fork
      wr(7'h68, 8'h01);
      cnt(60);
    join
    chk(16'(na), 16'h0001);
    wr(7'h67, 8'hff);
    chk({10'h000, bae}, 16'h003f);
    rd(7'h66, r);
    chk(r, 16'h3f0a);
    wr(7'h66, 8'h00);
    cnt(19200);
    chk(16'(ns), 16'h0040);
    chk(16'(nw), 16'h0001);
    wr(7'h62, 8'h02);
    wr(7'h63, 8'h00);
    wr(7'h60, 8'h09);
    // Let the period measured from the driven sync pin go stale first
    cnt(1200);
    fork
      host.sync_pulses(6, 40000);
      begin
        repeat (1700) @(negedge clk_sys);
        cnt(2400);
      end
    join
    chk(16'(ns >= 5 && ns <= 7), 16'h0001);
    chk(16'(no * 2 >= ns - 1 && no * 2 <= ns + 1), 16'h0001);
    complete_run();
  end
endmodule
bind imu_sample_timing imu_timing_chk chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .sample_tick(sample_tick), .output_tick(output_tick), .data_ready_pin(data_ready_pin),
  .sync_out(sync_out), .sync_oe(sync_oe), .burst_wide_active(burst_wide_active),
  .bias_window_done(bias_window_done), .bias_apply_command(bias_apply_command));
